// File: rtl/asrf_core.sv
// SAR bit resolution, result capture and formatted result reads
// Notes on behaviour
// - Resolve one bit per step, MSB first.
// - Start with MSB set, lower bits clear.
// - First decision keeps or clears the MSB.
// - Trial each lower bit; stop at 8/10.
// - Copy finished SAR into assigned result slot.
// - Three read views chosen by address.
// - Right view puts data in low bits.
// - Right view upper bits read zero.
// - Left views put data in top bits.
// - Left views lower bits read zero.
// - Signed view: bit 15 clear above mid-scale.
// - Mid-scale reference is the signed zero.
// - Resolution takes 10 or 12 clocks.
`timescale 1ns/1ps
`include "asrf_map.svh"
module asrf_core (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Conversion control
	input wire logic res_start,
	input wire logic res_10bit,
	input wire logic [2:0] res_slot,
	// Comparator
	input wire logic cmp_pass,
	output logic trial_ff,
	output logic [9:0] sar_ff,
	// Completion
	output logic done_ff,
	output logic busy_ff,
	// Result read port
	input wire logic rd_en,
	input wire logic [2:0] rd_idx,
	input wire asrf_pkg::asrf_view_t rd_view,
	output logic [15:0] rd_data_ff
);
	import asrf_pkg::*;

	// ****************************************
	// Sequencer state
	// ****************************************
	asrf_state_t state_ff; // Current state
	asrf_state_t nxt_state; // Next state
	logic [3:0] cyc_ff; // Cycles spent in resolution
	logic [3:0] bit_ff; // Bit under trial
	logic mode10_ff; // Latched resolution
	logic [2:0] slot_ff; // Latched destination slot
	logic [9:0] rslt_ff [`ASRF_NUM_RSLT]; // Result registers
	logic [`ASRF_NUM_RSLT-1:0] rmode_ff; // Result resolution per slot

	// ****************************************
	// Decode
	// ****************************************
	wire [3:0] nbits; // Bits to resolve
	wire [3:0] ncyc; // Resolution period length
	wire [3:0] top_bit; // MSB position in SAR
	wire deciding; // A trial bit is being decided
	wire last_cyc; // Final cycle of the period
	wire [9:0] trial_mask; // One-hot trial bit
	wire [9:0] next_mask; // One-hot of following bit
	wire [9:0] sar_decided; // SAR after this decision
	wire [15:0] view_word; // Formatted read word
	assign nbits = mode10_ff ? `ASRF_BITS_10 : `ASRF_BITS_8;
	assign ncyc = mode10_ff ? `ASRF_RES_CYC_10 : `ASRF_RES_CYC_8;
	assign top_bit = res_10bit ? 4'd9 : 4'd7;
	assign deciding = (state_ff == ASRF_RESOLVE) && (cyc_ff < nbits);
	assign last_cyc = (cyc_ff == ncyc - 4'd1);
	assign trial_mask = 10'h001 << bit_ff;
	assign next_mask = (bit_ff == 4'd0) ? 10'h000 : (10'h001 << (bit_ff - 4'd1));
	// Keep trial bit if passing, set the next trial bit
	assign sar_decided = (cmp_pass ? sar_ff : (sar_ff & ~trial_mask)) | next_mask;

	// State transitions
	always_comb begin
		case (state_ff)
			ASRF_IDLE: nxt_state = res_start ? ASRF_RESOLVE : ASRF_IDLE;
			ASRF_RESOLVE: nxt_state = last_cyc ? ASRF_FINISH : ASRF_RESOLVE;
			ASRF_FINISH: nxt_state = ASRF_IDLE;
			default: nxt_state = ASRF_IDLE;
		endcase
	end

	// ****************************************
	// Sequencer registers
	// ****************************************
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_ff <= ASRF_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Cycle counter and trial bit
	always_ff @(posedge mclk) begin
		if (srst) begin
			cyc_ff <= 4'd0;
			bit_ff <= 4'd0;
			mode10_ff <= 1'b0;
			slot_ff <= 3'h0;
		end else if (state_ff == ASRF_IDLE && res_start) begin
			cyc_ff <= 4'd0;
			bit_ff <= top_bit;
			mode10_ff <= res_10bit;
			slot_ff <= res_slot;
		end else if (state_ff == ASRF_RESOLVE) begin
			cyc_ff <= cyc_ff + 4'd1;
			if (deciding && bit_ff != 4'd0) begin
				bit_ff <= bit_ff - 4'd1;
			end
		end
	end

	// Approximation register
	always_ff @(posedge mclk) begin
		if (srst) begin
			sar_ff <= `ASRF_SAR_RST;
		end else if (state_ff == ASRF_IDLE && res_start) begin
			sar_ff <= 10'h001 << top_bit;
		end else if (deciding) begin
			sar_ff <= sar_decided;
		end
	end

	// Comparator trial strobe and status
	always_ff @(posedge mclk) begin
		if (srst) begin
			trial_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			trial_ff <= (nxt_state == ASRF_RESOLVE) && !(deciding && bit_ff == 4'd0)
				&& !(state_ff == ASRF_RESOLVE && cyc_ff >= nbits);
			busy_ff <= (nxt_state != ASRF_IDLE);
			done_ff <= (state_ff == ASRF_FINISH);
		end
	end

	// ****************************************
	// Result registers
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < `ASRF_NUM_RSLT; gi = gi + 1) begin : g_rslt
			always_ff @(posedge mclk) begin
				if (srst) begin
					rslt_ff[gi] <= `ASRF_SAR_RST;
					rmode_ff[gi] <= 1'b0;
				end else if (state_ff == ASRF_FINISH && slot_ff == 3'(gi)) begin
					rslt_ff[gi] <= sar_ff;
					rmode_ff[gi] <= mode10_ff;
				end
			end
		end
	endgenerate

	// ****************************************
	// Result read
	// ****************************************
	asrf_view u_view (
		.res(rslt_ff[rd_idx]),
		.res_10bit(rmode_ff[rd_idx]),
		.view(rd_view),
		.word(view_word)
	);

	// Registered read data
	always_ff @(posedge mclk) begin
		if (srst) begin
			rd_data_ff <= `ASRF_WORD_RST;
		end else if (rd_en) begin
			rd_data_ff <= view_word;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	// Selected result as seen by the read port
	wire [9:0] sel_res; // Stored value under read
	wire sel_10; // Its resolution
	wire sel_top; // Its most significant result bit
	logic [3:0] res_len_ff; // Resolve cycles counted by the checker
	assign sel_res = rslt_ff[rd_idx];
	assign sel_10 = rmode_ff[rd_idx];
	assign sel_top = sel_10 ? sel_res[9] : sel_res[7];

	// Checker count of resolve cycles, restarted between conversions
	always_ff @(posedge mclk) begin
		if (srst) begin
			res_len_ff <= 4'd0;
		end else if (state_ff == ASRF_IDLE) begin
			res_len_ff <= 4'd0; // Cleared while idle
		end else if (state_ff == ASRF_RESOLVE) begin
			res_len_ff <= res_len_ff + 4'd1; // One more resolve cycle
		end
	end

	// Start loads the top bit alone
	sar_start_a: assert property ((state_ff == ASRF_IDLE && res_start) |=>
		(sar_ff == ($past(res_10bit) ? 10'h200 : 10'h080)))
		else $error("SAR not loaded with MSB only");
	// Eight-bit period: ten resolve cycles then the store step
	period_len_a: assert property ((state_ff == ASRF_IDLE && res_start && !res_10bit) |=>
		(state_ff == ASRF_RESOLVE) [*8] ##1 (state_ff == ASRF_RESOLVE) [*2] ##1 (state_ff == ASRF_FINISH))
		else $error("8-bit resolution not ten cycles");
	// Ten-bit period: twelve resolve cycles then the store step
	period_10_a: assert property ((state_ff == ASRF_IDLE && res_start && res_10bit) |=>
		(state_ff == ASRF_RESOLVE) [*6] ##1 (state_ff == ASRF_RESOLVE) [*6] ##1 (state_ff == ASRF_FINISH))
		else $error("10-bit resolution not twelve cycles");
	// Resolve length by the checker count
	res_count_a: assert property ((state_ff == ASRF_FINISH) |->
		(res_len_ff == (mode10_ff ? `ASRF_RES_CYC_10 : `ASRF_RES_CYC_8)))
		else $error("Resolve cycle count wrong");
	// Failed comparison clears the trial bit
	clear_fail_a: assert property ((deciding && !cmp_pass) |=> !(|(sar_ff & $past(trial_mask))))
		else $error("Failed trial bit not cleared");
	// Passed comparison keeps the trial bit
	keep_pass_a: assert property ((deciding && cmp_pass) |=> (|(sar_ff & $past(trial_mask))))
		else $error("Passed trial bit lost");
	// Trials walk downward one bit at a time
	bit_order_a: assert property ((deciding && bit_ff != 4'd0) |=>
		(bit_ff == $past(bit_ff) - 4'd1))
		else $error("Trial bit not next lower");
	// A shown trial bit is set in the SAR
	trial_set_a: assert property (trial_ff |-> (|(sar_ff & trial_mask)))
		else $error("Trial bit not set");
	// Eight-bit conversions leave the top two bits clear
	top_clear_a: assert property ((state_ff != ASRF_IDLE && !mode10_ff) |->
		(sar_ff[9:8] == 2'h0))
		else $error("Eight-bit SAR uses upper bits");
	// A start while busy leaves the latched set-up alone
	busy_refuse_a: assert property ((state_ff != ASRF_IDLE && res_start) |=>
		($stable(slot_ff) && $stable(mode10_ff)))
		else $error("Start taken while busy");
	// Finished SAR lands in its slot
	capture_a: assert property ((state_ff == ASRF_FINISH) |=> (rslt_ff[$past(slot_ff)] == $past(sar_ff)))
		else $error("Result not captured");
	// Completion strobe lasts one cycle
	done_pulse_a: assert property (done_ff |=> !done_ff)
		else $error("Done longer than one cycle");
	// Signed view flips the top result bit
	signed_msb_a: assert property ((rd_en && rd_view == ASRF_VIEW_LJS) |=>
		(rd_data_ff[15] != $past(sel_top)))
		else $error("Signed view MSB not inverted");
	// Signed view keeps every other result bit
	signed_low_a: assert property ((rd_en && rd_view == ASRF_VIEW_LJS) |=>
		($past(sel_10) ? (rd_data_ff[14:6] == $past(sel_res[8:0]))
			: (rd_data_ff[14:8] == $past(sel_res[6:0]))))
		else $error("Signed view low bits altered");
	// Right view carries the result in the low bits
	rj_data_a: assert property ((rd_en && rd_view == ASRF_VIEW_RJU) |=>
		($past(sel_10) ? (rd_data_ff[9:0] == $past(sel_res))
			: (rd_data_ff[7:0] == $past(sel_res[7:0]))))
		else $error("Right view data misplaced");
	// Unsigned left view carries the result in the top bits
	lj_data_a: assert property ((rd_en && rd_view == ASRF_VIEW_LJU) |=>
		($past(sel_10) ? (rd_data_ff[15:6] == $past(sel_res))
			: (rd_data_ff[15:8] == $past(sel_res[7:0]))))
		else $error("Left view data misplaced");
	// Right view upper bits read zero
	rj_zero_a: assert property ((rd_en && rd_view == ASRF_VIEW_RJU) |=> (rd_data_ff[15:10] == 6'h00))
		else $error("Right view upper bits nonzero");
	// Eight-bit right view clears bits 15 to 8
	rj8_zero_a: assert property ((rd_en && rd_view == ASRF_VIEW_RJU && !sel_10) |=>
		(rd_data_ff[15:8] == 8'h00))
		else $error("Right view byte above data nonzero");
	// Left views lower bits read zero
	lj_zero_a: assert property ((rd_en && rd_view != ASRF_VIEW_RJU) |=> (rd_data_ff[5:0] == 6'h00))
		else $error("Left view lower bits nonzero");
	// Eight-bit left views clear the low byte
	lj8_zero_a: assert property ((rd_en && rd_view != ASRF_VIEW_RJU && !sel_10) |=>
		(rd_data_ff[7:0] == 8'h00))
		else $error("Left view low byte nonzero");
	// Read word holds until the next read
	read_hold_a: assert property (!rd_en |=> $stable(rd_data_ff))
		else $error("Read word changed without a read");

	// Main scenarios
	conv8_c: cover property ((state_ff == ASRF_FINISH) && !mode10_ff);
	conv10_c: cover property ((state_ff == ASRF_FINISH) && mode10_ff);
	read_ljs_c: cover property (rd_en && rd_view == ASRF_VIEW_LJS);
	busy_start_c: cover property (state_ff == ASRF_RESOLVE && res_start);
	read_rj8_c: cover property (rd_en && rd_view == ASRF_VIEW_RJU && !sel_10);
endmodule // asrf_core

// File: inc/asrf_map.svh
// Constants for the SAR result formatter: timing counts, field positions, reset values
`ifndef ASRF_MAP_SVH
`define ASRF_MAP_SVH

// ****************************************
// Resolution timing (converter clock cycles)
// ****************************************
`define ASRF_RES_CYC_8 4'd10
`define ASRF_RES_CYC_10 4'd12
`define ASRF_BITS_8 4'd8
`define ASRF_BITS_10 4'd10

// ****************************************
// Result word layout
// ****************************************
`define ASRF_SAR_MSB 9
`define ASRF_WORD_MSB 15
`define ASRF_LJ_LSB_10 6
`define ASRF_SAR_RST 10'h000
`define ASRF_WORD_RST 16'h0000

// ****************************************
// Result register file
// ****************************************
`define ASRF_NUM_RSLT 8
`define ASRF_IDX_W 3

`endif

// File: inc/asrf_pkg.sv
// Types shared by the SAR result formatter
package asrf_pkg;
	// Read views of a result register
	typedef enum logic [1:0] {
		ASRF_VIEW_RJU = 2'h0,
		ASRF_VIEW_LJS = 2'h1,
		ASRF_VIEW_LJU = 2'h2
	} asrf_view_t;
	// Resolution sequencer states
	typedef enum logic [1:0] {
		ASRF_IDLE,
		ASRF_RESOLVE,
		ASRF_FINISH
	} asrf_state_t;
endpackage

// File: rtl/asrf_view.sv
// Result word formatter for the three read views
`timescale 1ns/1ps
`include "asrf_map.svh"
module asrf_view (
	// Stored result
	input wire logic [9:0] res,
	input wire logic res_10bit,
	// View selection
	input wire asrf_pkg::asrf_view_t view,
	// Formatted word
	output logic [15:0] word
);
	import asrf_pkg::*;

	// ****************************************
	// Justification
	// ****************************************
	wire [15:0] rj_word; // Unsigned right-justified
	wire [15:0] lju_word; // Unsigned left-justified
	wire [15:0] ljs_word; // Signed left-justified
	// 8-bit results sit in res[7:0]; upper bits zero
	assign rj_word = res_10bit ? {6'h00, res} : {8'h00, res[7:0]};
	assign lju_word = res_10bit ? {res, 6'h00} : {res[7:0], 8'h00};
	// Mid-scale is zero: flip the top bit only
	assign ljs_word = {~lju_word[15], lju_word[14:0]};

	// Address-selected view
	assign word = (view == ASRF_VIEW_RJU) ? rj_word :
		(view == ASRF_VIEW_LJS) ? ljs_word : lju_word;
endmodule // asrf_view

// File: bench/tb_adc_sar_result_formatter.sv
// Self-checking bench for the SAR resolution and result formatter core
`timescale 1ns/1ps
module tb_adc_sar_result_formatter;
	import asrf_pkg::*;
	// ****************************************
	// Signals and bookkeeping
	// ****************************************
	logic mclk, srst, res_start, res_10bit, cmp_pass, rd_en;
	logic [2:0] res_slot, rd_idx;
	asrf_view_t rd_view;
	logic trial_ff, done_ff, busy_ff;
	logic [9:0] sar_ff;
	logic [15:0] rd_data_ff;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	// Expected contents of each result slot
	logic [9:0] exp_t [8];
	logic exp_b [8];
	// Targets: full scale, zero, both sides of mid-scale
	logic [9:0] tv [8] = '{10'h3ff, 10'h000, 10'h201, 10'h1ff, 10'h0ff, 10'h000, 10'h080, 10'h07f};

	asrf_core DUT (.mclk(mclk), .srst(srst), .res_start(res_start), .res_10bit(res_10bit),
		.res_slot(res_slot), .cmp_pass(cmp_pass), .trial_ff(trial_ff), .sar_ff(sar_ff),
		.done_ff(done_ff), .busy_ff(busy_ff), .rd_en(rd_en), .rd_idx(rd_idx),
		.rd_view(rd_view), .rd_data_ff(rd_data_ff));

	// ****************************************
	// Clock, timeout and reporting
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Cut a hang short
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// ****************************************
	// Scenario tasks
	// ****************************************
	// Acts as comparator toward tgt, checks each trial word and the timing
	task automatic conv(input logic b10, input logic [2:0] slot, input logic [9:0] tgt);
		logic [9:0] acc;
		logic [9:0] bv;
		int n;
		int msb;
		acc = 10'h000;
		msb = b10 ? 9 : 7;
		res_start = 1'b1;
		res_10bit = b10;
		res_slot = slot;
		@(posedge mclk) #1;
		res_start = 1'b0;
		res_10bit = ~b10;
		res_slot = ~slot;
		n = 0;
		for (int k = msb; k >= 0; k--) begin
			bv = 10'h001 << k;
			chk("sar_trial", {6'h00, acc | bv}, {6'h00, sar_ff});
			chk("trial_busy", 16'h0003, {14'h0000, trial_ff, busy_ff});
			// Decision for the shown trial, applied at the next edge
			cmp_pass = ((acc | bv) <= tgt);
			if (cmp_pass) acc = acc | bv;
			// A start while busy must be ignored
			res_start = (k == msb - 1);
			@(posedge mclk) #1;
			n++;
		end
		res_start = 1'b0;
		while (done_ff !== 1'b1 && n < 30) begin
			@(posedge mclk) #1;
			n++;
		end
		cmp_pass = 1'b0;
		// Resolve period, one store step, then the registered strobe
		chk("done_cycles", b10 ? 16'h000d : 16'h000b, 16'(n));
		chk("sar_final", {6'h00, tgt}, {6'h00, sar_ff});
		chk("idle_status", 16'h0000, {14'h0000, trial_ff, busy_ff});
		exp_t[slot] = tgt;
		exp_b[slot] = b10;
	endtask
	// Back-to-back read of one slot in one view; leaves rd_en high
	task automatic rd(input logic [2:0] slot, input asrf_view_t v);
		logic [15:0] e;
		e = exp_b[slot] ? {exp_t[slot], 6'h00} : {exp_t[slot][7:0], 8'h00};
		if (v == ASRF_VIEW_RJU) e = exp_b[slot] ? {6'h00, exp_t[slot]} : {8'h00, exp_t[slot][7:0]};
		if (v == ASRF_VIEW_LJS) e[15] = ~e[15];
		rd_en = 1'b1;
		rd_idx = slot;
		rd_view = v;
		@(posedge mclk) #1;
		chk("rd_data", e, rd_data_ff);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		srst = 1'b1;
		{res_start, res_10bit, cmp_pass, rd_en} = 4'h0;
		res_slot = 3'h0;
		rd_idx = 3'h0;
		rd_view = ASRF_VIEW_RJU;
		repeat (5) @(posedge mclk);
		#1 srst = 1'b0;
		// Back-to-back conversions into every slot
		for (int i = 0; i < 8; i++) conv(i < 4, 3'(i), tv[i]);
		for (int s = 0; s < 8; s++)
			for (int v = 0; v < 3; v++) rd(3'(s), asrf_view_t'(v));
		rd_en = 1'b0;
		// An 8-bit result replaces a 10-bit one; its neighbour is untouched
		conv(1'b0, 3'h0, 10'h0a5);
		for (int v = 0; v < 3; v++) rd(3'h0, asrf_view_t'(v));
		for (int v = 0; v < 3; v++) rd(3'h1, asrf_view_t'(v));
		rd_en = 1'b0;
		complete_run();
	end
endmodule // tb_adc_sar_result_formatter
